/* rtl/srg_pkg.sv */
// Package: constants and types for the supervisor reset generator
package srg_pkg;
  // Clock period in ns (100 MHz)
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least reset hold after all causes clear, in ms
  localparam int unsigned HOLD_MS = 140;
  // Hold in cycles, rounded up (least time)
  localparam longint unsigned HOLD_CYCLES_L =
    (longint'(HOLD_MS) * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYCLES = int'(HOLD_CYCLES_L);
  // Glitch filter length in cycles (stable samples needed)
  localparam int unsigned FILT_CYCLES = 4;
  // Counter widths
  localparam int unsigned HOLD_W = 24;
  localparam int unsigned FILT_W = 3;
  // Output styles
  localparam logic [1:0] STYLE_HIGH_PP = 2'h0;
  localparam logic [1:0] STYLE_LOW_PP  = 2'h1;
  localparam logic [1:0] STYLE_LOW_OD  = 2'h2;

  // Sequencer states
  typedef enum logic [1:0] {
    SRG_ASSERT = 2'b00,  // a cause is present
    SRG_HOLD   = 2'b01,  // causes gone, timeout running
    SRG_IDLE   = 2'b10   // reset released
  } srg_state_t;

  // Filter state: sync pair, filtered value, stability count
  typedef struct packed {
    logic              sync1;
    logic              sync2;
    logic              filt;
    logic [FILT_W-1:0] cnt;
  } srg_filt_t;

  // Sequencer state
  typedef struct packed {
    srg_state_t        state;
    logic [HOLD_W-1:0] cnt;
    logic              rst_o;
    logic              rst_oe;
  } srg_seq_t;
endpackage

/* rtl/srg_filter.sv */
// Two-flop synchroniser with a stability filter for one input
module srg_filter
  import srg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0  // Filtered value during reset
)
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);
  srg_filt_t s_reg;   // All state
  srg_filt_t s_next;  // Next state

  // Sync, then accept a new level only after it stands long enough
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = din;                 // [R12]
    s_next.sync2 = s_reg.sync1;         // [R12]
    if (s_reg.sync2 == s_reg.filt)
    begin
      s_next.cnt = '0;
    end
    else if (s_reg.cnt == FILT_W'(FILT_CYCLES - 1))
    begin
      s_next.filt = s_reg.sync2;        // [R9]
      s_next.cnt  = '0;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + FILT_W'(1);
    end
  end

  // Register the state
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{sync1: RESET_VAL, sync2: RESET_VAL, filt: RESET_VAL,
                 cnt: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.filt;

  // Short pulses never reach the output
  glitch_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(dout) |-> $past(s_reg.sync2, 1) == s_reg.filt
      && $past(s_reg.sync2, 4) == s_reg.filt)
    else $error("filtered output changed on a short pulse"); // [R9]
endmodule

/* rtl/srg_top.sv */
// Reset generation logic of a dual under-voltage supervisor
// Overview of operation
// R1: Reset asserted from power-on
// R2: Either monitor under-voltage asserts reset
// R3: Hold reset 140 ms after voltages good
// R4: Low manual reset asserts reset at once
// R5: Release 140 ms after manual reset released
// R6: Unconnected manual reset reads high
// R7: Partner drives manual reset, switch or open
// R8: Build-time output style: high, low, open-drain
// R9: Ignore brief glitches on monitored inputs
// R10: Partner holds manual reset low long enough
// R11: Cause during timeout restarts full timeout
// R12: Synchronise all inputs before reset decision
module srg_top
  import srg_pkg::*;
#(
  parameter logic [1:0]  OUT_STYLE   = STYLE_LOW_PP, // Output style [R8]
  parameter int unsigned HOLD_COUNT  = HOLD_CYCLES   // Shortenable hold
)
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic vdd_ok_in,         // Supply comparator, 1 = good
  input  wire logic vin_ok_in,         // Adjustable comparator, 1 = good
  input  wire logic manual_reset_n_in, // Manual reset, low requests
  input  wire logic manual_reset_pulled_in, // 1 when pin left open
  output logic      reset_out,         // Reset pin level
  output logic      reset_oe           // Reset pin drive enable
);
  logic vdd_ok;     // Filtered supply good
  logic vin_ok;     // Filtered adjustable good
  logic mr_raw;     // Manual reset with pull-up applied
  logic mr_n;       // Synchronised manual reset
  logic cause;      // Any reset cause present
  srg_seq_t s_reg;  // All state
  srg_seq_t s_next; // Next state

  // An open pin reads high, so it never requests reset
  always_comb
  begin
    mr_raw = manual_reset_n_in | manual_reset_pulled_in; // [R6] [R7]
  end

  // Monitors are filtered; they start as bad so power-on asserts
  srg_filter #(.RESET_VAL(1'b0)) u_vdd_filt
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (vdd_ok_in),
    .dout    (vdd_ok)
  );

  srg_filter #(.RESET_VAL(1'b0)) u_vin_filt
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (vin_ok_in),
    .dout    (vin_ok)
  );

  // Manual reset gets a plain two-flop sync only, no filter, so that
  // a short press is not lost; partner must hold it a few cycles
  logic mr_s1_reg;
  logic mr_s2_reg;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mr_s1_reg <= 1'b1;
      mr_s2_reg <= 1'b1;
    end
    else
    begin
      mr_s1_reg <= mr_raw;                // [R12] [R10]
      mr_s2_reg <= mr_s1_reg;
    end
  end
  assign mr_n = mr_s2_reg;

  // Reset cause: either monitor bad or manual reset low
  always_comb
  begin
    cause = !vdd_ok || !vin_ok || !mr_n;  // [R2] [R4]
  end

  // Map asserted level onto the chosen pin style
  function automatic logic [1:0] drive(input logic asserted);
    logic [1:0] r;
    r = 2'h0;
    if (OUT_STYLE == STYLE_HIGH_PP)
    begin
      r = {asserted, 1'b1};
    end
    else if (OUT_STYLE == STYLE_LOW_OD)
    begin
      r = {1'b0, asserted};               // [R8] drive low only
    end
    else
    begin
      r = {!asserted, 1'b1};
    end
    return r;
  endfunction

  // Sequencer: assert, hold timeout, release
  always_comb
  begin
    logic [1:0] pin;
    pin = 2'h0;
    s_next = s_reg;
    case (s_reg.state)
      SRG_ASSERT:
      begin
        s_next.cnt = '0;
        if (!cause)
        begin
          s_next.state = SRG_HOLD;        // [R3] [R5]
        end
      end
      SRG_HOLD:
      begin
        if (cause)
        begin
          s_next.state = SRG_ASSERT;      // [R11]
          s_next.cnt   = '0;
        end
        else if (s_reg.cnt >= HOLD_W'(HOLD_COUNT - 1))
        begin
          s_next.state = SRG_IDLE;        // [R3] [R5]
        end
        else
        begin
          s_next.cnt = s_reg.cnt + HOLD_W'(1);
        end
      end
      SRG_IDLE:
      begin
        if (cause)
        begin
          s_next.state = SRG_ASSERT;      // [R2] [R4]
        end
      end
      default:
      begin
        s_next.state = SRG_ASSERT;
      end
    endcase
    pin = drive(s_next.state != SRG_IDLE);
    s_next.rst_o  = pin[1];
    s_next.rst_oe = pin[0];
  end

  // Register the state; reset leaves the output asserted
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg.state  <= SRG_ASSERT;                          // [R1]
      s_reg.cnt    <= '0;
      s_reg.rst_o  <= (OUT_STYLE == STYLE_HIGH_PP) ? 1'b1 : 1'b0;
      s_reg.rst_oe <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign reset_out = s_reg.rst_o;
  assign reset_oe  = s_reg.rst_oe;

  logic asserted;  // Output asserted, any style
  assign asserted = (OUT_STYLE == STYLE_HIGH_PP) ? reset_out
                  : (reset_oe && !reset_out);

  // Assertions
  por_asserted_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(arst_n) |-> asserted) else $error("no reset at power-on"); // [R1]
  cause_asserts_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cause |=> asserted) else $error("cause did not assert reset"); // [R2]
  manual_immed_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !mr_n |=> asserted) else $error("manual reset ignored"); // [R4]
  hold_min_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(asserted) |-> $past(s_reg.cnt) == HOLD_W'(HOLD_COUNT - 1))
    else $error("reset released before timeout"); // [R3]
  manual_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(mr_n) && vdd_ok && vin_ok |=> asserted [*8])
    else $error("manual release too early"); // [R5]
  restart_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.state == SRG_HOLD && cause |=> s_reg.cnt == '0)
    else $error("timeout not restarted"); // [R11]
  od_style_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    OUT_STYLE == STYLE_LOW_OD |-> !reset_out)
    else $error("open-drain drove high"); // [R8]
  sync_delay_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(mr_raw) ##1 !mr_raw |=> !mr_n)
    else $error("manual reset sync wrong"); // [R12]
  pull_up_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    manual_reset_pulled_in [*3] |-> mr_n)
    else $error("open pin requested reset"); // [R6]
  // Pin level must mirror the sequencer in every style
  out_level_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    asserted == (s_reg.state != SRG_IDLE))
    else $error("pin level does not follow state"); // [R8]
  // Count stops at the end value, never wraps into a short hold
  cnt_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.cnt <= HOLD_W'(HOLD_COUNT - 1))
    else $error("timeout count overran"); // [R3]
  // Every hold starts from zero, so a restart gets the full time
  hold_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.state == SRG_HOLD && $past(s_reg.state) == SRG_ASSERT
      |-> s_reg.cnt == '0)
    else $error("hold did not start from zero"); // [R11]

  release_c: cover property (@(posedge sys_clk) $fell(asserted));
  manual_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.state == SRG_IDLE && !mr_n);
  restart_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.state == SRG_HOLD && cause && s_reg.cnt != '0);
  power_on_c: cover property (@(posedge sys_clk) $rose(arst_n));
  monitor_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    s_reg.state == SRG_IDLE && (!vdd_ok || !vin_ok));
endmodule

/* tb/srg_partner.sv */
// Reset receiver model: turns the reset pin into an in-reset flag
module srg_partner
  import srg_pkg::*;
#(
  parameter logic [1:0] STYLE = STYLE_LOW_PP // Pin style seen
)
(
  input  wire logic pin_out,  // Level driven by the block
  input  wire logic pin_oe,   // Drive enable of the block
  output logic      in_reset  // Receiver held in reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_lvl; // Wire level seen by the receiver
  // Undriven open-drain pin floats up to the board pull-up
  assign pin_lvl = pin_oe ? pin_out : 1'b1;
  // Polarity follows the build-time style
  assign in_reset = (STYLE == STYLE_HIGH_PP) ? pin_lvl : !pin_lvl;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the supervisor reset generator
module testbench
  import srg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HC = 20; // Short hold keeps the run brief
  localparam int LIMIT = 3000;     // Cycle ceiling of the run
  // Rows: supply, adjustable, manual, pin open, reset expected
  localparam logic [4:0] ROWS [7] =
    '{5'h0D, 5'h15, 5'h05, 5'h19, 5'h1A, 5'h1C, 5'h09};
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       vdd_ok  = 1'b1;
  logic       vin_ok  = 1'b1;
  logic       mr_n    = 1'b1;
  logic       mr_pu   = 1'b0;
  logic [2:0] rst_pin;         // Pin level per style
  logic [2:0] rst_oe;          // Pin enable per style
  logic [2:0] in_rst;          // Receiver view per style
  logic [2:0] seen;            // Sticky reset seen in a window
  int         n_mismatch = 0;
  int         n_checks   = 0;
  int         cyc        = 0;
  int         n;
  // Free-running system clock
  always #5 sys_clk = ~sys_clk;
  // One block and one receiver for every output style
  for (genvar g = 0; g < 3; g++)
  begin : gen_style
    srg_top #(
      .OUT_STYLE  (2'(g)),
      .HOLD_COUNT (HC)
    ) srg_top_inst (
      .sys_clk                (sys_clk),
      .arst_n                 (arst_n),
      .vdd_ok_in              (vdd_ok),
      .vin_ok_in              (vin_ok),
      .manual_reset_n_in      (mr_n),
      .manual_reset_pulled_in (mr_pu),
      .reset_out              (rst_pin[g]),
      .reset_oe               (rst_oe[g])
    );
    srg_partner #(
      .STYLE (2'(g))
    ) srg_partner_inst (
      .pin_out  (rst_pin[g]),
      .pin_oe   (rst_oe[g]),
      .in_reset (in_rst[g])
    );
  end
  task automatic chk(input string what, input logic [2:0] got,
                     input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Apply one row: supply, adjustable, manual, pin open
  task automatic drive(input logic [4:0] r);
    @(negedge sys_clk);
    {vdd_ok, vin_ok, mr_n, mr_pu} = r[4:1];
  endtask
  // Cycles until every receiver leaves reset, bounded
  task automatic wait_rel(output int cnt);
    cnt = 0;
    while (in_rst !== 3'b000 && cnt < 200)
    begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (20) @(negedge sys_clk);
    chk("reset level", in_rst, 3'b111);
    chk("reset pins", rst_pin, 3'b001);
    chk("reset enables", rst_oe, 3'b111);
    arst_n = 1'b1;
    wait_rel(n);
    chk("power hold", {3{n >= HC && n <= HC + 20}}, 3'b111);
    chk("idle pins", rst_pin, 3'b010);
    chk("idle enables", rst_oe, 3'b011);
    foreach (ROWS[i])
    begin
      drive(ROWS[i]);
      repeat (12) @(negedge sys_clk);
      chk("row level", in_rst, {3{ROWS[i][0]}});
      drive(5'h1C);
      wait_rel(n);
      if (ROWS[i][0])
        chk("row hold", {3{n >= HC && n <= HC + 12}}, 3'b111);
    end
    // Manual low passes the synchroniser before acting
    drive(5'h18);
    @(negedge sys_clk);
    chk("sync delay", in_rst, 3'b000);
    repeat (2) @(negedge sys_clk);
    chk("manual at once", in_rst, 3'b111);
    // New cause halfway through the hold, 50 ns low
    drive(5'h1C);
    repeat (HC / 2) @(negedge sys_clk);
    drive(5'h18);
    repeat (4) @(negedge sys_clk);
    drive(5'h1C);
    wait_rel(n);
    chk("restart hold", {3{n >= HC && n <= HC + 12}}, 3'b111);
    // Two-cycle supply dip must not start a sequence
    drive(5'h0C);
    drive(5'h0C);
    drive(5'h1C);
    seen = 3'b000;
    repeat (15)
    begin
      @(negedge sys_clk);
      seen |= in_rst;
    end
    chk("glitch ignored", seen, 3'b000);
    // Second reset in mid-run
    @(negedge sys_clk);
    arst_n = 1'b0;
    #1;
    chk("async reset", in_rst, 3'b111);
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    wait_rel(n);
    chk("rerun hold", {3{n >= HC && n <= HC + 20}}, 3'b111);
    end_of_test();
  end
endmodule
